// [pulse_edge_quadrature_counter.v]
/*
 * Frequency-input measurement unit: pulse counting, period averaging,
 * edge timing and quadrature decoding for a datalogger.
 * Assumes a scan scheduler that pulses scan_start and reads results one
 * cycle later; all sensor pins are asynchronous to mclk.
 */
`timescale 1ns/1ps
`include "pulse_edge_map.vh"
module pulse_edge_quadrature_counter #(
    parameter DEB_CYC = `DEBOUNCE_CYC,
    parameter TIMEOUT_CYC = `TIMEOUT_CYC,
    parameter [15:0] PAVG_CYCLES = 16'h000a
)(
    input wire mclk,
    input wire reset,
    input wire pulse_pin,
    input wire ctrl_pin_a,
    input wire ctrl_pin_b,
    input wire single_ended_input,
    input wire scan_start,
    input wire switch_mode,
    input wire [1:0] pulse_out_sel,
    input wire pavg_step,
    input wire pavg_freq_sel,
    input wire [1:0] timing_mode,
    input wire [1:0] timing_out_sel,
    input wire [1:0] quad_mode,
    input wire [2:0] func_req_a,
    input wire [2:0] func_req_b,
    input wire func_req_valid,
    output reg [2:0] func_a_q,
    output reg [2:0] func_b_q,
    output reg func_refused_q,
    output reg [31:0] pulse_result_q,
    output reg pulse_invalid_q,
    output reg [31:0] pavg_result_q,
    output reg pavg_done_q,
    output reg [31:0] timing_result_q,
    output reg timing_nan_q,
    output reg timing_done_q,
    output reg [31:0] quad_net_q,
    output reg [31:0] quad_cw_q,
    output reg [31:0] quad_ccw_q,
    output reg quad_dir_cw_q
);
    // ======================================================================
    // Shared arithmetic.
    function [31:0] cyc_to_us;
        input [31:0] cyc;
        begin
            cyc_to_us = cyc / `CYC_PER_US;
        end
    endfunction

    function [31:0] cyc_to_hz;
        input [31:0] cyc;
        begin
            if (cyc == 32'h0)
                cyc_to_hz = 32'h0;
            else
                cyc_to_hz = `CLK_HZ / cyc;
        end
    endfunction

    wire p_rise;
    wire se_rise;
    wire a_lvl;
    wire a_rise;
    wire a_fall;
    wire b_lvl;
    wire b_rise;
    wire b_fall;

    // ======================================================================
    // Input conditioning for every pin.
    input_conditioner #(.DEB_CYC(DEB_CYC), .INVERT(1)) u_pulse (
        .mclk(mclk),
        .reset(reset),
        .pin(pulse_pin),
        .debounce_en(switch_mode),
        .level_q(),
        .rise(p_rise),
        .fall()
    );

    input_conditioner #(.DEB_CYC(DEB_CYC), .INVERT(0)) u_se (
        .mclk(mclk),
        .reset(reset),
        .pin(single_ended_input),
        .debounce_en(1'b0),
        .level_q(),
        .rise(se_rise),
        .fall()
    );

    input_conditioner #(.DEB_CYC(DEB_CYC), .INVERT(0)) u_ca (
        .mclk(mclk),
        .reset(reset),
        .pin(ctrl_pin_a),
        .debounce_en(1'b0),
        .level_q(a_lvl),
        .rise(a_rise),
        .fall(a_fall)
    );

    input_conditioner #(.DEB_CYC(DEB_CYC), .INVERT(0)) u_cb (
        .mclk(mclk),
        .reset(reset),
        .pin(ctrl_pin_b),
        .debounce_en(1'b0),
        .level_q(b_lvl),
        .rise(b_rise),
        .fall(b_fall)
    );

    // ======================================================================
    // Control-port pair assignment: a terminal holding a special function
    // blocks its partner from any other special function.
    wire conflict;
    assign conflict = (func_req_a != `FN_NONE) && (func_req_b != `FN_NONE)
        && (func_req_a != func_req_b);

    always @(posedge mclk)
    begin
        if (reset)
        begin
            func_a_q <= `FN_NONE;
            func_b_q <= `FN_NONE;
            func_refused_q <= 1'b0;
        end
        else if (func_req_valid)
        begin
            func_refused_q <= conflict;
            if (!conflict)
            begin
                func_a_q <= func_req_a;
                func_b_q <= func_req_b;
            end
        end
    end

    // ======================================================================
    // Pulse accumulator: counts every cycle regardless of scans, latched and
    // cleared at scan start. An edge in the latch cycle starts the new count.
    reg [31:0] pcnt_q;
    reg pwrap_q;
    reg [31:0] avg_q;
    wire [32:0] pcnt_inc;
    wire [31:0] scan_cyc_hz;
    reg [31:0] scan_len_q;
    reg [31:0] scan_cnt_q;

    assign pcnt_inc = {1'b0, pcnt_q} + 33'h1;
    assign scan_cyc_hz = cyc_to_hz(scan_cnt_q);

    always @(posedge mclk)
    begin
        if (reset)
        begin
            pcnt_q <= 32'h0;
            pwrap_q <= 1'b0;
            scan_cnt_q <= 32'h0;
            scan_len_q <= 32'h0;
            avg_q <= 32'h0;
            pulse_result_q <= 32'h0;
            pulse_invalid_q <= 1'b0;
        end
        else
        begin
            scan_cnt_q <= scan_start ? 32'h1 : scan_cnt_q + 32'h1;
            if (scan_start)
            begin
                // Frequency = counts per scan scaled by scan length.
                scan_len_q <= scan_cnt_q;
                pulse_invalid_q <= pwrap_q;
                avg_q <= avg_q - (avg_q >> `AVG_SHIFT)
                    + ((pcnt_q * scan_cyc_hz) >> `AVG_SHIFT);
                case (pulse_out_sel)
                    `OUT_COUNT: pulse_result_q <= pcnt_q;
                    `OUT_FREQ: pulse_result_q <= pcnt_q * scan_cyc_hz;
                    `OUT_AVG: pulse_result_q <= avg_q;
                    default: pulse_result_q <= pcnt_q;
                endcase
                pcnt_q <= p_rise ? 32'h1 : 32'h0;
                pwrap_q <= 1'b0;
            end
            else if (p_rise)
            begin
                pcnt_q <= pcnt_inc[31:0];
                if (pcnt_inc[32])
                    pwrap_q <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Period averaging: only while its scan step is active, times a fixed
    // number of cycles of the input against the reference clock.
    reg [31:0] pavg_cyc_q;
    reg [15:0] pavg_edges_q;
    reg pavg_run_q;

    always @(posedge mclk)
    begin
        if (reset)
        begin
            pavg_cyc_q <= 32'h0;
            pavg_edges_q <= 16'h0;
            pavg_run_q <= 1'b0;
            pavg_result_q <= 32'h0;
            pavg_done_q <= 1'b0;
        end
        else
        begin
            pavg_done_q <= 1'b0;
            if (!pavg_step)
            begin
                pavg_run_q <= 1'b0;
                pavg_edges_q <= 16'h0;
            end
            else if (se_rise)
            begin
                if (!pavg_run_q)
                begin
                    pavg_run_q <= 1'b1;
                    pavg_cyc_q <= 32'h0;
                    pavg_edges_q <= 16'h0;
                end
                else if (pavg_edges_q == PAVG_CYCLES - 16'h1)
                begin
                    pavg_run_q <= 1'b0;
                    pavg_done_q <= 1'b1;
                    pavg_result_q <= pavg_freq_sel ?
                        cyc_to_hz((pavg_cyc_q + 32'h1) / {16'h0, PAVG_CYCLES}) :
                        cyc_to_us((pavg_cyc_q + 32'h1) / {16'h0, PAVG_CYCLES});
                end
                else
                begin
                    pavg_edges_q <= pavg_edges_q + 16'h1;
                    pavg_cyc_q <= pavg_cyc_q + 32'h1;
                end
            end
            else if (pavg_run_q)
                pavg_cyc_q <= pavg_cyc_q + 32'h1;
        end
    end

    // ======================================================================
    // Edge timing on terminal B, rising edges; terminal A is the previous
    // terminal for the from-previous mode. Span mode keeps its start across
    // scan_start so an interval may straddle the boundary.
    reg [31:0] tcnt_q;
    reg tarm_q;
    wire t_start;
    wire [31:0] t_val;

    assign t_start = (timing_mode == `TMODE_FROM_PREV) ? a_rise : b_rise;
    assign t_val = tcnt_q + 32'h1;

    always @(posedge mclk)
    begin
        if (reset)
        begin
            tcnt_q <= 32'h0;
            tarm_q <= 1'b0;
            timing_result_q <= 32'h0;
            timing_nan_q <= 1'b0;
            timing_done_q <= 1'b0;
        end
        else
        begin
            timing_done_q <= 1'b0;
            if (scan_start && timing_mode != `TMODE_SPAN && tarm_q)
                tarm_q <= 1'b0;
            else if (tarm_q && b_rise)
            begin
                timing_done_q <= 1'b1;
                timing_nan_q <= (t_val < `MIN_EDGE_CYC);
                case (timing_out_sel)
                    `OUT_FREQ: timing_result_q <= cyc_to_hz(t_val);
                    default: timing_result_q <= cyc_to_us(t_val);
                endcase
                tcnt_q <= 32'h0;
                tarm_q <= (timing_mode == `TMODE_SUCCESSIVE) ||
                    (timing_mode == `TMODE_SPAN);
            end
            else if (tarm_q && tcnt_q >= TIMEOUT_CYC - 1)
            begin
                timing_done_q <= 1'b1;
                timing_nan_q <= 1'b1;
                timing_result_q <= 32'h0;
                tarm_q <= 1'b0;
            end
            else if (tarm_q)
                tcnt_q <= tcnt_q + 32'h1;
            else if (t_start)
            begin
                tarm_q <= 1'b1;
                tcnt_q <= 32'h0;
            end
        end
    end

    // ======================================================================
    // Quadrature decoding on the A/B pair; counts clear on scan start.
    wire [31:0] q_net;
    wire [31:0] q_cw;
    wire [31:0] q_ccw;
    wire q_dir;

    quad_decoder u_quad (
        .mclk(mclk),
        .reset(reset),
        .mode(quad_mode),
        .a(a_lvl),
        .b(b_lvl),
        .clear(scan_start),
        .net_q(q_net),
        .cw_q(q_cw),
        .ccw_q(q_ccw),
        .dir_cw_q(q_dir)
    );

    // Results are snapshotted at scan start so the scheduler reads stable values.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            quad_net_q <= 32'h0;
            quad_cw_q <= 32'h0;
            quad_ccw_q <= 32'h0;
            quad_dir_cw_q <= 1'b1;
        end
        else if (scan_start)
        begin
            quad_net_q <= q_net;
            quad_cw_q <= q_cw;
            quad_ccw_q <= q_ccw;
            quad_dir_cw_q <= q_dir;
        end
    end
endmodule // pulse_edge_quadrature_counter

// [pulse_edge_map.vh]
/*
 * Constants for the pulse, edge-timing and quadrature measurement unit.
 * Assumes a 10 MHz system clock; included by its bare name.
 */
`ifndef PULSE_EDGE_MAP_VH
`define PULSE_EDGE_MAP_VH

// ==========================================================================
// Output selections and modes
`define OUT_COUNT 2'h0
`define OUT_FREQ 2'h1
`define OUT_AVG 2'h2
`define QMODE_X1 2'h0
`define QMODE_X2 2'h1
`define QMODE_X4 2'h2
`define TMODE_SINGLE 2'h0
`define TMODE_SUCCESSIVE 2'h1
`define TMODE_FROM_PREV 2'h2
`define TMODE_SPAN 2'h3
// Terminal function codes for the pair-conflict check.
`define FN_NONE 3'h0
`define FN_SERIAL 3'h1
`define FN_TIMING 3'h2
`define FN_COUNT 3'h3
`define FN_TRIGGER 3'h4

// ==========================================================================
// Timing
`define CLK_HZ 10000000
`define DEBOUNCE_US 2000
`define DEBOUNCE_CYC ((`DEBOUNCE_US * (`CLK_HZ / 1000000)))
`define TIMEOUT_US 1000000
`define TIMEOUT_CYC ((`TIMEOUT_US * (`CLK_HZ / 1000000)))
`define MIN_EDGE_CYC 2
`define CYC_PER_US 10
`define AVG_SHIFT 2

`endif

// [input_conditioner.v]
/*
 * Two-flop synchroniser with optional inversion and debounce.
 * Assumes the input is asynchronous to mclk.
 */
`timescale 1ns/1ps
`include "pulse_edge_map.vh"
module input_conditioner #(
    parameter DEB_CYC = `DEBOUNCE_CYC,
    parameter INVERT = 0
)(
    input wire mclk,
    input wire reset,
    input wire pin,
    input wire debounce_en,
    output reg level_q,
    output reg rise,
    output reg fall
);
    reg s1_q;
    reg s2_q;
    reg [31:0] deb_cnt_q;
    wire raw;

    // ======================================================================
    // Synchroniser; the first flop is read only by the second.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
        end
    end

    // The inverting stage sits after synchronisation, which is equivalent here.
    assign raw = (INVERT != 0) ? ~s2_q : s2_q;

    // ======================================================================
    // With debounce_en set, a new level is accepted only after it holds for the debounce time, so a
    // bouncing contact gives one edge; this caps the switch-closure rate.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            level_q <= (INVERT != 0) ? 1'b1 : 1'b0; // Idle level; no false edge.
            deb_cnt_q <= 32'h0;
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (raw == level_q)
                deb_cnt_q <= 32'h0;
            else if (!debounce_en || deb_cnt_q >= DEB_CYC - 1)
            begin
                level_q <= raw;
                deb_cnt_q <= 32'h0;
                rise <= raw;
                fall <= ~raw;
            end
            else
                deb_cnt_q <= deb_cnt_q + 32'h1;
        end
    end
endmodule // input_conditioner

// [quad_decoder.v]
/*
 * Quadrature decoder for one encoder pair in x1, x2 or x4 counting.
 * Assumes synchronised A and B levels from input_conditioner.
 */
`timescale 1ns/1ps
`include "pulse_edge_map.vh"
module quad_decoder (
    input wire mclk,
    input wire reset,
    input wire [1:0] mode,
    input wire a,
    input wire b,
    input wire clear,
    output reg [31:0] net_q,
    output reg [31:0] cw_q,
    output reg [31:0] ccw_q,
    output reg dir_cw_q
);
    reg a_q;
    reg b_q;
    reg up;
    reg dn;
    wire ach;
    wire bch;

    assign ach = a ^ a_q;
    assign bch = b ^ b_q;

    // ======================================================================
    // Direction: on an A edge, A leads when the new A differs from B; on a B
    // edge, A leads when the new B equals A.
    always @*
    begin
        up = 1'b0;
        dn = 1'b0;
        if (ach && bch)
        begin
            up = 1'b0;
            dn = 1'b0;
        end
        else if (ach)
        begin
            case (mode)
                `QMODE_X1:
                begin
                    up = a && !b;
                    dn = !a && !b;
                end
                `QMODE_X2, `QMODE_X4:
                begin
                    up = (a != b);
                    dn = (a == b);
                end
                default:
                begin
                    up = 1'b0;
                    dn = 1'b0;
                end
            endcase
        end
        else if (bch && mode == `QMODE_X4)
        begin
            up = (b == a);
            dn = (b != a);
        end
    end

    // ======================================================================
    // Counters; a clear in the same cycle as a step keeps the step.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            net_q <= 32'h0;
            cw_q <= 32'h0;
            ccw_q <= 32'h0;
            dir_cw_q <= 1'b1;
        end
        else
        begin
            a_q <= a;
            b_q <= b;
            net_q <= (clear ? 32'h0 : net_q) + (up ? 32'h1 : 32'h0)
                - (dn ? 32'h1 : 32'h0);
            cw_q <= (clear ? 32'h0 : cw_q) + (up ? 32'h1 : 32'h0);
            ccw_q <= (clear ? 32'h0 : ccw_q) + (dn ? 32'h1 : 32'h0);
            if (up)
                dir_cw_q <= 1'b1;
            else if (dn)
                dir_cw_q <= 1'b0;
        end
    end
endmodule // quad_decoder

// [counter_props.sv]
/*
 * Port-level checker for the pulse, edge and quadrature measurement unit.
 * Assumes one mclk domain with a synchronous active-high reset; bound from tb.
 */
`timescale 1ns/1ps
module counter_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scan_start,
    input wire logic pavg_step,
    input wire logic [2:0] func_req_a,
    input wire logic [2:0] func_req_b,
    input wire logic func_req_valid,
    input wire logic [2:0] func_a_q,
    input wire logic [2:0] func_b_q,
    input wire logic func_refused_q,
    input wire logic [31:0] pulse_result_q,
    input wire logic pavg_done_q,
    input wire logic timing_done_q,
    input wire logic [31:0] quad_net_q,
    input wire logic quad_dir_cw_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ==========================================================
    // Pair assignment requests
    sequence s_conflict;
        func_req_valid && func_req_a != 3'h0 && func_req_b != 3'h0 && func_req_a != func_req_b;
    endsequence
    sequence s_accept;
        func_req_valid && !(func_req_a != 3'h0 && func_req_b != 3'h0 && func_req_a != func_req_b);
    endsequence
    property p_refuse;
        s_conflict |=> func_refused_q && func_a_q == $past(func_a_q) && func_b_q == $past(func_b_q);
    endproperty
    a_refuse: assert property (p_refuse) else $error("conflicting request not refused");
    property p_accept;
        s_accept |=> !func_refused_q && func_a_q == $past(func_req_a) && func_b_q == $past(func_req_b);
    endproperty
    a_accept: assert property (p_accept) else $error("legal request not taken");
    property p_func_hold;
        $changed(func_a_q) || $changed(func_b_q) |-> $past(func_req_valid) || $past(reset);
    endproperty
    a_func_hold: assert property (p_func_hold) else $error("assignment moved unasked");

    // ==========================================================
    // Results, done pulses and reset
    // The reset check must not be disabled by the reset it watches.
    property p_reset_vals;
        disable iff (1'b0) reset |=> pulse_result_q == 32'h0 && quad_net_q == 32'h0
            && quad_dir_cw_q && !func_refused_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
    property p_pulse_hold;
        $changed(pulse_result_q) |-> $past(scan_start) || $past(reset);
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse result off scan");
    property p_quad_hold;
        $changed(quad_net_q) || $changed(quad_dir_cw_q) |-> $past(scan_start) || $past(reset);
    endproperty
    a_quad_hold: assert property (p_quad_hold) else $error("quad result off scan");
    property p_pavg_done_one;
        pavg_done_q |=> !pavg_done_q;
    endproperty
    a_pavg_done_one: assert property (p_pavg_done_one) else $error("pavg done too long");
    property p_tim_done_one;
        timing_done_q |=> !timing_done_q;
    endproperty
    a_tim_done_one: assert property (p_tim_done_one) else $error("timing done too long");
    property p_pavg_gated;
        !pavg_step [*4] |-> !pavg_done_q;
    endproperty
    a_pavg_gated: assert property (p_pavg_gated) else $error("pavg done with step idle");
endmodule // counter_props

// [sensor_model.sv]
/*
 * Behavioural far side: a rotary encoder, a pulse sensor with optional
 * contact bounce and a frequency source on the single-ended line.
 * Assumes its tasks are called from tb; all changes follow a rising mclk edge.
 */
`timescale 1ns/1ps
module sensor_model (
    input wire logic mclk,
    output logic enc_a,
    output logic enc_b,
    output logic pulse_line,
    output logic se_line
);
    int phase;

    // ==========================================================
    // Idle levels at time zero.
    initial
    begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        pulse_line = 1'b0;
        se_line = 1'b0;
        phase = 0;
    end

    // Encoder steps are spaced 5 cycles so the synchroniser sees each one.
    task automatic quad_move(input int steps, input bit cw);
        for (int i = 0; i < steps; i++)
        begin
            phase = cw ? (phase + 1) % 4 : (phase + 3) % 4;
            @(posedge mclk);
            enc_a <= (phase == 1 || phase == 2);
            enc_b <= (phase == 2 || phase == 3);
            repeat (4) @(posedge mclk);
        end
    endtask

    // Both channels jump together, which a real encoder never should.
    task automatic quad_jump(input int n);
        for (int i = 0; i < 2 * n; i++)
        begin
            @(posedge mclk);
            enc_a <= ~enc_a;
            enc_b <= ~enc_b;
            repeat (4) @(posedge mclk);
        end
    endtask

    // Bounce is a few single-cycle flips, well under the debounce time.
    task automatic pulses(input int n, input bit bounce);
        for (int i = 0; i < n; i++)
        begin
            for (int k = 0; k < (bounce ? 4 : 0); k++)
            begin
                @(posedge mclk);
                pulse_line <= ~pulse_line;
            end
            @(posedge mclk);
            pulse_line <= 1'b1;
            repeat (12) @(posedge mclk);
            pulse_line <= 1'b0;
            repeat (12) @(posedge mclk);
        end
    endtask

    task automatic se_toggle(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            se_line <= ~se_line;
            repeat (2) @(posedge mclk);
        end
    endtask
endmodule // sensor_model

// [tb.sv]
/*
 * Self-checking testbench for pulse_edge_quadrature_counter.
 * Assumes counter_props.sv and sensor_model.sv are compiled before it.
 */
`timescale 1ns/1ps
module tb;
    logic mclk, reset, scan_start, switch_mode, pavg_step, pavg_freq_sel, func_req_valid;
    logic [1:0] pulse_out_sel, timing_mode, timing_out_sel, quad_mode;
    logic [2:0] func_req_a, func_req_b, func_a_q, func_b_q;
    logic func_refused_q, pulse_invalid_q, pavg_done_q, timing_nan_q, timing_done_q;
    logic quad_dir_cw_q, enc_a, enc_b, pulse_line, se_line;
    logic [31:0] pulse_result_q, pavg_result_q, timing_result_q, quad_net_q, quad_cw_q, quad_ccw_q;
    int fail_count = 0;
    int check_count = 0;

    // ==========================================================
    // Clock, partner and design; short counts keep the run brief.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    sensor_model i_sensor (.mclk(mclk), .enc_a(enc_a), .enc_b(enc_b),
        .pulse_line(pulse_line), .se_line(se_line));
    pulse_edge_quadrature_counter #(.DEB_CYC(4), .TIMEOUT_CYC(100)) i_dut (
        .mclk(mclk), .reset(reset), .pulse_pin(pulse_line), .ctrl_pin_a(enc_a),
        .ctrl_pin_b(enc_b), .single_ended_input(se_line), .scan_start(scan_start),
        .switch_mode(switch_mode), .pulse_out_sel(pulse_out_sel), .pavg_step(pavg_step),
        .pavg_freq_sel(pavg_freq_sel), .timing_mode(timing_mode), .timing_out_sel(timing_out_sel),
        .quad_mode(quad_mode), .func_req_a(func_req_a), .func_req_b(func_req_b),
        .func_req_valid(func_req_valid), .func_a_q(func_a_q), .func_b_q(func_b_q),
        .func_refused_q(func_refused_q), .pulse_result_q(pulse_result_q),
        .pulse_invalid_q(pulse_invalid_q), .pavg_result_q(pavg_result_q), .pavg_done_q(pavg_done_q),
        .timing_result_q(timing_result_q), .timing_nan_q(timing_nan_q),
        .timing_done_q(timing_done_q), .quad_net_q(quad_net_q), .quad_cw_q(quad_cw_q),
        .quad_ccw_q(quad_ccw_q), .quad_dir_cw_q(quad_dir_cw_q));

    // ==========================================================
    // Shared helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Results are looked at on the falling edge, well after they settle.
    task automatic scan();
        @(posedge mclk);
        scan_start <= 1'b1;
        @(posedge mclk);
        scan_start <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        @(negedge mclk);
        check(quad_dir_cw_q, 1'b1);
        check(pulse_result_q, 32'h0);
        check(quad_net_q, 32'h0);
    endtask

    // Counting runs between scans, and each scan reads then clears.
    task automatic t_pulse(input bit sw, input int n);
        @(posedge mclk) switch_mode <= sw;
        scan();
        i_sensor.pulses(n, sw);
        repeat (10) @(posedge mclk);
        scan();
        check(pulse_result_q, n);
        check(pulse_invalid_q, 1'b0);
        scan();
        check(pulse_result_q, 32'h0);
    endtask

    // One full cycle gives 1, 2 or 4 counts in x1, x2, x4.
    task automatic t_quad();
        for (int m = 0; m < 3; m++)
        begin
            @(posedge mclk) quad_mode <= m[1:0];
            scan();
            i_sensor.quad_move(12, 1'b1);
            repeat (6) @(posedge mclk);
            scan();
            check(quad_net_q, 3 << m);
            check(quad_cw_q, 3 << m);
            check(quad_dir_cw_q, 1'b1);
            i_sensor.quad_move(8, 1'b0);
            repeat (6) @(posedge mclk);
            scan();
            check(quad_net_q, -(2 << m));
            check(quad_ccw_q, 2 << m);
            check(quad_dir_cw_q, 1'b0);
        end
        i_sensor.quad_jump(3);
        repeat (6) @(posedge mclk);
        scan();
        check(quad_net_q, 32'h0);
        check(quad_cw_q, 32'h0);
    endtask

    // Each special function against the next code (4 against 1) is refused.
    task automatic t_func();
        for (int f = 1; f < 5; f++)
        begin
            @(posedge mclk);
            func_req_valid <= 1'b1;
            func_req_a <= f[2:0];
            func_req_b <= 3'h0;
            @(posedge mclk);
            func_req_a <= f[2:0];
            func_req_b <= (f == 4) ? 3'h1 : f[2:0] + 3'h1;
            @(posedge mclk);
            func_req_valid <= 1'b0;
            @(negedge mclk);
            check(func_refused_q, 1'b1);
            check(func_a_q, f);
            check(func_b_q, 3'h0);
        end
    endtask

    // Input edges outside the step window must give no result.
    task automatic t_pavg_idle();
        @(posedge mclk) pavg_step <= 1'b0;
        fork
            i_sensor.se_toggle(20);
            repeat (60)
            begin
                @(negedge mclk);
                check(pavg_done_q, 1'b0);
            end
        join
    endtask

    // Six-cycle input period, then B every 20 cycles, then a timeout.
    task automatic t_meas();
        @(posedge mclk) {pavg_step, pavg_freq_sel, timing_mode} <= 4'hd;
        i_sensor.se_toggle(24);
        check(pavg_result_q, 10000000 / 6);
        i_sensor.quad_move(9, 1'b1);
        check(timing_result_q, 32'h2);
        check(timing_nan_q, 1'b0);
        repeat (110) @(posedge mclk);
        check(timing_nan_q, 1'b1);
    endtask

    // ==========================================================
    // Main sequence and watchdog.
    initial
    begin
        reset = 1'b1;
        scan_start = 1'b0;
        switch_mode = 1'b0;
        pavg_step = 1'b0;
        pavg_freq_sel = 1'b0;
        func_req_valid = 1'b0;
        pulse_out_sel = 2'h0;
        timing_mode = 2'h0;
        timing_out_sel = 2'h0;
        quad_mode = 2'h0;
        func_req_a = 3'h0;
        func_req_b = 3'h0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_pulse(1'b0, 5);
        t_pulse(1'b1, 3);
        t_quad();
        t_func();
        t_pavg_idle();
        t_meas();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule // tb

bind pulse_edge_quadrature_counter counter_props i_props (
    .mclk(mclk), .reset(reset), .scan_start(scan_start), .pavg_step(pavg_step),
    .func_req_a(func_req_a), .func_req_b(func_req_b), .func_req_valid(func_req_valid),
    .func_a_q(func_a_q), .func_b_q(func_b_q), .func_refused_q(func_refused_q),
    .pulse_result_q(pulse_result_q), .pavg_done_q(pavg_done_q),
    .timing_done_q(timing_done_q), .quad_net_q(quad_net_q), .quad_dir_cw_q(quad_dir_cw_q));
